//--- core/isp_pkg.sv
// Package: special register numbers, bit positions and reset values of the SPR bank
`default_nettype none
package isp_pkg;
  // Big-endian bit n of a register sits at vector index MSB_IDX - n
  localparam int          MSB_IDX       = 31;
  localparam int          DATA_W        = 32;
  localparam int          SPR_NUM_W     = 10;

  // Special register numbers
  localparam logic [9:0]  SPR_PM_CTL0   = 10'h3B8;
  localparam logic [9:0]  SPR_CLK_CFG   = 10'h3F1;
  localparam logic [9:0]  SPR_IMPL_CTL0 = 10'h3F0;

  // implementation_control_0 fields
  localparam int          IC0_BHT_EN    = MSB_IDX - 29;
  localparam int          IC0_BTC_DIS   = MSB_IDX - 30;

  // clock_config_readback fields
  localparam int          PLL_CFG_W     = 4;
  localparam int          CLK_PLL_LSB   = MSB_IDX - 3;

  // perf_monitor_control_0 fields
  localparam int          PM0_FRZ_ALL   = MSB_IDX - 0;
  localparam int          PM0_FRZ_SUP   = MSB_IDX - 1;
  localparam int          PM0_FRZ_USR   = MSB_IDX - 2;
  localparam int          PM0_FRZ_MSET  = MSB_IDX - 3;
  localparam int          PM0_FRZ_MCLR  = MSB_IDX - 4;
  localparam int          PM0_IRQ_EN    = MSB_IDX - 5;
  localparam int          PM0_FRZ_IRQ   = MSB_IDX - 6;
  localparam int          PM0_TB_IRQ    = MSB_IDX - 9;
  localparam int          PM0_TRIGGER   = MSB_IDX - 18;

  // Table sizes handed to the predictor
  localparam int          BHT_ENTRIES   = 512;
  localparam int          BTC_ENTRIES   = 64;

  // Reset values
  localparam logic [31:0] IC0_RESET     = 32'h0000_0000;
  localparam logic [31:0] PM0_RESET     = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // One move-to / move-from special register request
  typedef struct packed {
    logic [9:0]  num;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } isp_spr_req_s;

  // Answer to a request, one cycle later
  typedef struct packed {
    logic        ack;
    logic        priv_fault;
    logic        unmapped;
    logic [31:0] rdata;
  } isp_spr_rsp_s;
endpackage
`default_nettype wire

//--- core/isp_spr_bank.sv
// Module: implementation special registers for branch prediction and monitor control
// Functional notes
// - History enable bit 29 selects table prediction, clear means static prediction.
// - History enable bit resets to zero at power-on.
// - History table keeps training while disabled for prediction.
// - Target cache disable clear: cache predicts and accepts new entries.
// - Disable set: cache invalidated, treated empty, no allocation until cleared.
// - Set then clear disable in two writes flushes; cache returns empty and enabled.
// - Clock readback register 1009 supervisor-only; bits 0-3 show PLL inputs.
// - Clock readback bits 4-31 read zero; whole register read-only.
// - Monitor control 0 is 32-bit register 952, supervisor read and write only.
// - Monitor control 0 resets to zero; reads leave it unchanged.
// - Bit 0 set: counters never changed by hardware.
// - Bit 1 set and supervisor state: counters frozen.
// - Bit 2 set and user state: counters frozen.
// - Bit 3 set and process mark one: counters frozen.
// - Bit 4 set and process mark zero: counters frozen.
// - Bit 5 gates monitor interrupt signalling.
// - Hardware clears bit 5 on interrupt; software re-arms it.
// - Bit 6 clear: interrupt does not change counting.
// - Bit 6 set: interrupt freezes counter 1, others too when trigger is zero.
// - Bit 9 set: timebase bit rising edge signals an interrupt.
// - Bit 18 holds counters 2-4 until counter 1 bit 0 or an interrupt.
`default_nettype none
module isp_spr_bank #(
  parameter int PLL_W = isp_pkg::PLL_CFG_W
) (
  input  wire logic                  i_sys_clk,       // Core clock, 25 MHz
  input  wire logic                  i_rst_n,         // Power-on reset, async, low
  input  wire isp_pkg::isp_spr_req_s i_spr_req,       // Move-to/from register request
  input  wire logic                  i_privilege_state_bit, // 1 user, 0 supervisor
  input  wire logic                  i_process_mark_bit,    // Process mark of machine state
  input  wire logic [PLL_W-1:0]      i_pll_cfg,       // PLL config pins, [3] is cfg bit 0
  input  wire logic                  i_cnt_neg_irq,   // Qualified counter-negative condition
  input  wire logic                  i_tb_rise,       // Selected timebase bit rose
  input  wire logic                  i_cnt1_bit0,     // Sign bit of event_counter_1
  output var  isp_pkg::isp_spr_rsp_s o_spr_rsp,       // Answer, one cycle after request
  output logic                       o_bht_predict_en,// Use branch_history_table
  output logic                       o_bht_update_en, // Train branch_history_table
  output logic                       o_btc_enable,    // Use and fill branch_target_cache
  output logic                       o_btc_invalidate,// Hold branch_target_cache empty
  output logic                       o_pm_irq,        // Monitor interrupt pulse
  output logic                       o_cnt1_freeze,   // Hold event_counter_1
  output logic                       o_cntx_freeze    // Hold event_counters 2 to 4
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ic0_q;
  logic [31:0] pm0_q;
  logic [31:0] pm0_d;
  logic        irq_frozen_q;
  logic        trig_open_q;
  logic        sup;
  logic        req;
  logic        wr_ic0;
  logic        wr_pm0;
  logic        irq_ev;
  logic        frz_base;
  logic        frz1_d;
  logic        frzx_d;

  function automatic logic hit(input logic [9:0] num, input logic [9:0] spr);
    hit = (num == spr);
  endfunction

  assign sup    = ~i_privilege_state_bit;
  assign req    = i_spr_req.wr | i_spr_req.rd;
  assign wr_ic0 = i_spr_req.wr & sup & hit(i_spr_req.num, isp_pkg::SPR_IMPL_CTL0);
  assign wr_pm0 = i_spr_req.wr & sup & hit(i_spr_req.num, isp_pkg::SPR_PM_CTL0);

  ////////////////////////////////////////////////////////////////////////////
  // implementation_control_0
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ic0_q <= isp_pkg::IC0_RESET;
    end else if (wr_ic0) begin
      ic0_q <= isp_pkg::ZERO_WORD;
      ic0_q[isp_pkg::IC0_BHT_EN]  <= i_spr_req.wdata[isp_pkg::IC0_BHT_EN];
      ic0_q[isp_pkg::IC0_BTC_DIS] <= i_spr_req.wdata[isp_pkg::IC0_BTC_DIS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bht_predict_en <= 1'b0;
      o_bht_update_en  <= 1'b0;
      o_btc_enable     <= 1'b0;
      o_btc_invalidate <= 1'b0;
    end else begin
      o_bht_predict_en <= ic0_q[isp_pkg::IC0_BHT_EN];
      o_bht_update_en  <= 1'b1;
      o_btc_enable     <= ~ic0_q[isp_pkg::IC0_BTC_DIS];
      o_btc_invalidate <= ic0_q[isp_pkg::IC0_BTC_DIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // perf_monitor_control_0 and monitor interrupt
  assign irq_ev = pm0_q[isp_pkg::PM0_IRQ_EN] &
                  (i_cnt_neg_irq | (pm0_q[isp_pkg::PM0_TB_IRQ] & i_tb_rise));

  always_comb begin
    pm0_d = pm0_q;
    if (wr_pm0) begin
      pm0_d = i_spr_req.wdata;
    end
    if (irq_ev) begin
      pm0_d[isp_pkg::PM0_IRQ_EN] = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pm0_q <= isp_pkg::PM0_RESET;
    end else begin
      pm0_q <= pm0_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pm_irq <= 1'b0;
    end else begin
      o_pm_irq <= irq_ev;
    end
  end

  // Sticky freeze after an interrupt, released by a supervisor write to the register in a cycle without a new interrupt
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_frozen_q <= 1'b0;
    end else if (irq_ev) begin
      irq_frozen_q <= 1'b1;
    end else if (wr_pm0) begin
      irq_frozen_q <= 1'b0;
    end
  end

  // Trigger opens on counter 1 sign bit or an interrupt; closed again by a write
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_open_q <= 1'b0;
    end else if (i_cnt1_bit0 | irq_ev) begin
      trig_open_q <= 1'b1;
    end else if (wr_pm0) begin
      trig_open_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter freeze
  always_comb begin
    frz_base = pm0_q[isp_pkg::PM0_FRZ_ALL]
             | (pm0_q[isp_pkg::PM0_FRZ_SUP]  & ~i_privilege_state_bit)
             | (pm0_q[isp_pkg::PM0_FRZ_USR]  &  i_privilege_state_bit)
             | (pm0_q[isp_pkg::PM0_FRZ_MSET] &  i_process_mark_bit)
             | (pm0_q[isp_pkg::PM0_FRZ_MCLR] & ~i_process_mark_bit);
    frz1_d   = frz_base | (pm0_q[isp_pkg::PM0_FRZ_IRQ] & (irq_frozen_q | irq_ev));
    frzx_d   = frz_base
             | (pm0_q[isp_pkg::PM0_FRZ_IRQ] & ~pm0_q[isp_pkg::PM0_TRIGGER]
                & (irq_frozen_q | irq_ev))
             | (pm0_q[isp_pkg::PM0_TRIGGER] & ~(trig_open_q | i_cnt1_bit0 | irq_ev));
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cnt1_freeze <= 1'b0;
      o_cntx_freeze <= 1'b0;
    end else begin
      o_cnt1_freeze <= frz1_d;
      o_cntx_freeze <= frzx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request answer: read data, privilege fault, unmapped number
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_spr_rsp <= '0;
    end else begin
      o_spr_rsp.ack        <= req;
      o_spr_rsp.priv_fault <= 1'b0;
      o_spr_rsp.unmapped   <= 1'b0;
      o_spr_rsp.rdata      <= isp_pkg::ZERO_WORD;
      if (req) begin
        if (!(hit(i_spr_req.num, isp_pkg::SPR_IMPL_CTL0) |
              hit(i_spr_req.num, isp_pkg::SPR_PM_CTL0) |
              hit(i_spr_req.num, isp_pkg::SPR_CLK_CFG))) begin
          o_spr_rsp.unmapped <= 1'b1;
        end else if (!sup) begin
          o_spr_rsp.priv_fault <= 1'b1;
        end else if (i_spr_req.rd && !i_spr_req.wr) begin
          if (hit(i_spr_req.num, isp_pkg::SPR_IMPL_CTL0)) begin
            o_spr_rsp.rdata <= ic0_q;
          end else if (hit(i_spr_req.num, isp_pkg::SPR_PM_CTL0)) begin
            o_spr_rsp.rdata <= pm0_q;
          end else begin
            o_spr_rsp.rdata[isp_pkg::CLK_PLL_LSB +: PLL_W] <= i_pll_cfg;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic clk_wr;
  assign clk_wr = i_spr_req.wr & hit(i_spr_req.num, isp_pkg::SPR_CLK_CFG);

  bht_reset_a: assert property (@(posedge i_sys_clk)
    $rose(i_rst_n) |-> !o_bht_predict_en)
    else $error("history table enabled out of reset");

  bht_follow_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_ic0 |-> ##2 o_bht_predict_en == $past(i_spr_req.wdata[isp_pkg::IC0_BHT_EN], 2))
    else $error("history enable did not follow write");

  btc_flush_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_btc_invalidate |-> !o_btc_enable)
    else $error("target cache usable while invalidated");

  clk_ro_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (clk_wr && !irq_ev) |=> $stable(ic0_q) && $stable(pm0_q))
    else $error("write to readback register changed state");

  clk_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_spr_rsp.ack |-> o_spr_rsp.rdata[isp_pkg::CLK_PLL_LSB-1:0] == '0 ||
      !$past(hit(i_spr_req.num, isp_pkg::SPR_CLK_CFG)))
    else $error("readback reserved bits not zero");

  pm_priv_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_spr_req.wr && i_privilege_state_bit && !irq_ev) |=> $stable(pm0_q))
    else $error("user write changed monitor control");

  irq_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_pm_irq |-> !pm0_q[isp_pkg::PM0_IRQ_EN] ##1 !o_pm_irq)
    else $error("interrupt enable not cleared after signal");

  irq_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !pm0_q[isp_pkg::PM0_IRQ_EN] |=> !o_pm_irq)
    else $error("interrupt signalled while disabled");

  frz_all_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pm0_q[isp_pkg::PM0_FRZ_ALL] |=> o_cnt1_freeze && o_cntx_freeze)
    else $error("counters not frozen by freeze_all_counters");

  frz_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (irq_ev && pm0_q[isp_pkg::PM0_FRZ_IRQ] && !wr_pm0) |=> o_cnt1_freeze [*2])
    else $error("counter 1 not frozen after interrupt");

  frz_user_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (pm0_q[isp_pkg::PM0_FRZ_USR] && i_privilege_state_bit) |=> o_cnt1_freeze)
    else $error("counter 1 counting in user state");

  frz_sup_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (pm0_q[isp_pkg::PM0_FRZ_SUP] && !i_privilege_state_bit) |=> o_cnt1_freeze && o_cntx_freeze)
    else $error("counters counting in supervisor state");

  frz_mset_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (pm0_q[isp_pkg::PM0_FRZ_MSET] && i_process_mark_bit) |=> o_cnt1_freeze && o_cntx_freeze)
    else $error("counters counting with mark set");

  frz_mclr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (pm0_q[isp_pkg::PM0_FRZ_MCLR] && !i_process_mark_bit) |=> o_cnt1_freeze && o_cntx_freeze)
    else $error("counters counting with mark clear");

  bht_train_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    1'b1 |=> o_bht_update_en)
    else $error("history table training stopped");

  bht_static_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ic0_q[isp_pkg::IC0_BHT_EN] |=> !o_bht_predict_en)
    else $error("history prediction on while disabled");

  btc_use_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ic0_q[isp_pkg::IC0_BTC_DIS] |=> o_btc_enable && !o_btc_invalidate)
    else $error("target cache not usable while enabled");

  btc_empty_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ic0_q[isp_pkg::IC0_BTC_DIS] |=> o_btc_invalidate)
    else $error("target cache not held empty");

  btc_back_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_ic0 && !i_spr_req.wdata[isp_pkg::IC0_BTC_DIS]) |-> ##2 o_btc_enable && !o_btc_invalidate)
    else $error("target cache not back after flush");

  clk_user_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (req && !sup && hit(i_spr_req.num, isp_pkg::SPR_CLK_CFG)) |=>
      o_spr_rsp.priv_fault && o_spr_rsp.rdata == '0)
    else $error("readback register open to user state");

  clk_pll_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_spr_req.rd && !i_spr_req.wr && sup && hit(i_spr_req.num, isp_pkg::SPR_CLK_CFG)) |=>
      o_spr_rsp.rdata[isp_pkg::CLK_PLL_LSB +: PLL_W] == $past(i_pll_cfg))
    else $error("readback does not show PLL pins");

  pm_reset_a: assert property (@(posedge i_sys_clk)
    $rose(i_rst_n) |-> pm0_q == isp_pkg::PM0_RESET)
    else $error("monitor control not zero out of reset");

  pm_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_spr_req.rd && !i_spr_req.wr && !irq_ev) |=> $stable(pm0_q))
    else $error("read changed monitor control");

  irq_tb_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (pm0_q[isp_pkg::PM0_IRQ_EN] && pm0_q[isp_pkg::PM0_TB_IRQ] && i_tb_rise) |=> o_pm_irq)
    else $error("timebase edge gave no interrupt");

  frz_noirq_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (irq_ev && !pm0_q[isp_pkg::PM0_FRZ_IRQ] && !frz_base && !pm0_q[isp_pkg::PM0_TRIGGER])
      |=> !o_cnt1_freeze && !o_cntx_freeze)
    else $error("interrupt froze counters with bit 6 clear");

  trig_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (pm0_q[isp_pkg::PM0_TRIGGER] && !trig_open_q && !i_cnt1_bit0 && !irq_ev) |=> o_cntx_freeze)
    else $error("chained counters not held by trigger");

  trig_free_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!pm0_q[isp_pkg::PM0_TRIGGER] && !frz_base && !pm0_q[isp_pkg::PM0_FRZ_IRQ])
      |=> !o_cntx_freeze)
    else $error("chained counters held without cause");

  ack_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    req |=> o_spr_rsp.ack)
    else $error("request not answered");

  user_frz_c:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cnt1_freeze && i_privilege_state_bit);
  clk_read_c:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_spr_rsp.ack && o_spr_rsp.rdata != '0);

  irq_cov_c:   cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_pm_irq);
  flush_cov_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(o_btc_invalidate));
  trig_cov_c:  cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(o_cntx_freeze) && pm0_q[isp_pkg::PM0_TRIGGER]);
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Testbench: self-checking run of the branch and monitor control register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          max_cyc = 3000;
  localparam logic [31:0] ic_mask = (32'h1 << isp_pkg::IC0_BHT_EN) | (32'h1 << isp_pkg::IC0_BTC_DIS);
  localparam logic [31:0] b5      = 32'h1 << isp_pkg::PM0_IRQ_EN;
  localparam logic [31:0] b6      = 32'h1 << isp_pkg::PM0_FRZ_IRQ;
  localparam logic [31:0] b9      = 32'h1 << isp_pkg::PM0_TB_IRQ;
  localparam logic [31:0] b18     = 32'h1 << isp_pkg::PM0_TRIGGER;
  logic                  i_sys_clk = 1'b0;
  logic                  i_rst_n   = 1'b0;
  isp_pkg::isp_spr_req_s req       = '0;
  logic                  priv      = 1'b0;
  logic                  mark      = 1'b0;
  logic [3:0]            pll       = 4'h0;
  logic                  cnt_neg   = 1'b0;
  logic                  tb_rise   = 1'b0;
  logic                  c1b0      = 1'b0;
  isp_pkg::isp_spr_rsp_s rsp;
  logic                  bht_p, bht_u, btc_e, btc_i, irq, f1, fx, seen;
  isp_pkg::isp_spr_rsp_s exp_q[$];
  int                    miscompares = 0;
  int                    checked     = 0;
  int                    cycles      = 0;
  int                    irq_cnt     = 0;
  logic [31:0]           wv;

  always #20 i_sys_clk = ~i_sys_clk;

  isp_spr_bank i_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_spr_req(req), .i_privilege_state_bit(priv),
    .i_process_mark_bit(mark), .i_pll_cfg(pll), .i_cnt_neg_irq(cnt_neg), .i_tb_rise(tb_rise),
    .i_cnt1_bit0(c1b0), .o_spr_rsp(rsp), .o_bht_predict_en(bht_p), .o_bht_update_en(bht_u),
    .o_btc_enable(btc_e), .o_btc_invalidate(btc_i), .o_pm_irq(irq), .o_cnt1_freeze(f1),
    .o_cntx_freeze(fx));

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  function automatic isp_pkg::isp_spr_rsp_s ans(input logic pf, input logic um, input logic [31:0] d);
    ans = '{ack: 1'b1, priv_fault: pf, unmapped: um, rdata: d};
  endfunction

  task automatic acc(input logic [9:0] n, input logic w, input logic [31:0] d, input logic p,
                     input isp_pkg::isp_spr_rsp_s e);
    @(posedge i_sys_clk);
    req <= '{num: n, wr: w, rd: ~w, wdata: d};
    priv <= p;
    exp_q.push_back(e);
  endtask

  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    acc(n, 1'b1, d, 1'b0, ans(1'b0, 1'b0, 32'h0000_0000));
  endtask

  task automatic rd(input logic [9:0] n, input logic [31:0] d);
    acc(n, 1'b0, 32'h0000_0000, 1'b0, ans(1'b0, 1'b0, d));
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      req <= '0;
    end
  endtask

  task automatic pulse(input logic tb);
    @(posedge i_sys_clk);
    req <= '0;
    if (tb) tb_rise <= 1'b1;
    else cnt_neg <= 1'b1;
    @(posedge i_sys_clk);
    tb_rise <= 1'b0;
    cnt_neg <= 1'b0;
  endtask

  task automatic frz(input logic e1, input logic ex);
    idle(3);
    #1;
    chk(35'({f1, fx}), 35'({e1, ex}));
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  // Response watcher: every answer is matched against the oldest note
  always @(posedge i_sys_clk) begin
    if (rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) chk(rsp, 35'h0);
      else chk(rsp, exp_q.pop_front());
    end
    if (irq === 1'b1) irq_cnt++;
    cycles++;
    if (cycles == max_cyc) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(29199));
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(isp_pkg::SPR_IMPL_CTL0, 32'h0000_0000);
    rd(isp_pkg::SPR_PM_CTL0, 32'h0000_0000);
    idle(2);
    #1;
    chk(35'({bht_p, bht_u, btc_e, btc_i}), 35'h6);
    for (int i = 0; i < 4; i++) begin
      wv = $urandom;
      wv[isp_pkg::IC0_BHT_EN] = i[0];
      wv[isp_pkg::IC0_BTC_DIS] = i[1];
      wr(isp_pkg::SPR_IMPL_CTL0, wv);
      rd(isp_pkg::SPR_IMPL_CTL0, wv & ic_mask);
      idle(2);
      #1;
      chk(35'({bht_p, bht_u, btc_e, btc_i}), 35'({i[0], 1'b1, ~i[1], i[1]}));
    end
    // Flush by set then clear in two back-to-back writes; the set write also sets history enable
    wr(isp_pkg::SPR_IMPL_CTL0, 32'h0000_0000);
    wr(isp_pkg::SPR_IMPL_CTL0, ic_mask);
    wr(isp_pkg::SPR_IMPL_CTL0, 32'h0000_0000);
    seen = 1'b0;
    repeat (4) begin
      @(posedge i_sys_clk);
      req <= '0;
      #1;
      if (btc_i === 1'b1) seen = 1'b1;
    end
    chk(35'({seen, btc_e, btc_i}), 35'h6);
    // Clock configuration readback
    wv = $urandom;
    @(posedge i_sys_clk);
    pll <= wv[3:0];
    rd(isp_pkg::SPR_CLK_CFG, {wv[3:0], 28'h0});
    wr(isp_pkg::SPR_CLK_CFG, 32'hFFFF_FFFF);
    rd(isp_pkg::SPR_CLK_CFG, {wv[3:0], 28'h0});
    acc(isp_pkg::SPR_CLK_CFG, 1'b0, 32'h0, 1'b1, ans(1'b1, 1'b0, 32'h0));
    // Monitor control register access
    wv = $urandom;
    wr(isp_pkg::SPR_PM_CTL0, wv);
    acc(isp_pkg::SPR_PM_CTL0, 1'b1, ~wv, 1'b1, ans(1'b1, 1'b0, 32'h0));
    acc(isp_pkg::SPR_PM_CTL0, 1'b0, 32'h0, 1'b1, ans(1'b1, 1'b0, 32'h0));
    rd(isp_pkg::SPR_PM_CTL0, wv);
    rd(isp_pkg::SPR_PM_CTL0, wv);
    acc(10'h3B9, 1'b0, 32'h0, 1'b0, ans(1'b0, 1'b1, 32'h0));
    // Freeze conditions against privilege and process mark
    for (int b = 0; b < 5; b++) begin
      for (int c = 0; c < 4; c++) begin
        wr(isp_pkg::SPR_PM_CTL0, 32'h1 << (isp_pkg::MSB_IDX - b));
        @(posedge i_sys_clk);
        req <= '0;
        priv <= c[0];
        mark <= c[1];
        seen = (b == 0) | (b == 1 & !c[0]) | (b == 2 & c[0]) | (b == 3 & c[1]) | (b == 4 & !c[1]);
        frz(seen, seen);
      end
    end
    @(posedge i_sys_clk);
    mark <= 1'b0;
    // Interrupt signalling, hardware clear and freeze on interrupt
    wr(isp_pkg::SPR_PM_CTL0, b5 | b6);
    pulse(1'b0);
    frz(1'b1, 1'b1);
    chk(35'(irq_cnt), 35'h1);
    rd(isp_pkg::SPR_PM_CTL0, b6);
    pulse(1'b0);
    idle(3);
    chk(35'(irq_cnt), 35'h1);
    wr(isp_pkg::SPR_PM_CTL0, b5);
    pulse(1'b1);
    idle(3);
    chk(35'(irq_cnt), 35'h1);
    wr(isp_pkg::SPR_PM_CTL0, b5 | b9);
    pulse(1'b1);
    frz(1'b0, 1'b0);
    chk(35'(irq_cnt), 35'h2);
    // Chained trigger holds counters 2 to 4
    wr(isp_pkg::SPR_PM_CTL0, b18);
    frz(1'b0, 1'b1);
    @(posedge i_sys_clk);
    c1b0 <= 1'b1;
    frz(1'b0, 1'b0);
    c1b0 <= 1'b0;
    wr(isp_pkg::SPR_PM_CTL0, b5 | b6 | b18);
    pulse(1'b0);
    frz(1'b1, 1'b0);
    chk(35'(irq_cnt), 35'h3);
    idle(3);
    end_of_test();
  end
endmodule
`default_nettype wire
